// file: design/exec_unit.sv
/*
  Integer execution unit with general registers, single-cycle ALU, bypass,
  leading count and a parallel product/quotient unit with upper/bottom result registers.
  Assumes the integer pipeline holds an instruction while a stall output forbids it,
  and never presents an instruction reading pending_idx_o while pending_valid_o is high.
*/
// Behaviour
// - Logical, shift, add and subtract results in one cycle; load/store only.
// - Thirty-two general registers of 32 bits each.
// - Leading zero and leading one count of a word.
// - Fresh results, except full-width register products, are forwarded to the next instruction without stalling.
// - Product/quotient unit advances on its own, whatever the pipeline does.
// - Booth recoded 32x16 multiplier; results in upper and bottom result registers.
// - Pass count from source B width only; 16-bit source B takes one pass.
// - Full 32-bit source B passes the multiplier twice.
// - Short product every cycle; full-width product at most every other cycle.
// - Full-width product right after another full-width product is stalled.
// - Operand size is detected by hardware, not by encoding.
// - Divide resolves one quotient bit per clock.
// - Early-in skips 23, 15 or 7 iterations for 8, 16, 24-bit dividends.
// - Unit instructions stall until the last cycle of a running divide.
// - Result-register products: latency/repeat 1/1 short, 2/2 full width.
// - Register product: repeat 1 short; latency 3, repeat 2 full width.
// - Divide latency/repeat 12/11, 19/18, 26/25, 33/32 by dividend width.
`timescale 1ns/100ps
`default_nettype none
module exec_unit
  import exec_unit_pkg::*;
#(
  parameter int NREG = NUM_GENERAL_REGS
) (
  input  wire logic            core_clk_i,
  input  wire logic            resetn_i,
  input  wire logic            issue_valid_i,
  input  wire op_type          op_i,
  input  wire logic [IDXW-1:0] src_a_idx_i,
  input  wire logic [IDXW-1:0] src_b_idx_i,
  input  wire logic [IDXW-1:0] dest_idx_i,
  input  wire logic            load_valid_i,
  input  wire logic [IDXW-1:0] load_idx_i,
  input  wire logic [XLEN-1:0] load_data_i,
  input  wire logic [IDXW-1:0] read_idx_i,
  output logic      [XLEN-1:0] read_data_o,
  output logic      [XLEN-1:0] result_o,
  output logic      [IDXW-1:0] result_idx_o,
  output logic                 result_valid_o,
  output logic                 issue_stall_o,
  output logic                 pqu_stall_o,
  output logic                 pending_valid_o,
  output logic      [IDXW-1:0] pending_idx_o,
  output logic                 div_busy_o,
  output logic      [XLEN-1:0] upper_result_o,
  output logic      [XLEN-1:0] bottom_result_o
);
  typedef struct packed {
    logic [NREG-1:0][XLEN-1:0] regs;
    logic [XLEN-1:0]           res;
    logic [IDXW-1:0]           res_idx;
    logic                      res_valid;
    logic [XLEN-1:0]           mulw;
    logic                      mulw_valid;
    logic [XLEN-1:0]           up;
    logic [XLEN-1:0]           bot;
    pqu_state_type             mst;
    logic [63:0]               acc;
    logic [XLEN:0]             a33;
    logic [HALFW:0]            bhi;
    logic [1:0]                mode;
    logic                      to_reg;
    logic [IDXW-1:0]           dest;
    logic [XLEN-1:0]           rem;
    logic [XLEN-1:0]           quo;
    logic [XLEN-1:0]           dvs;
    logic [COUNTW-1:0]         iters;
    logic [COUNTW-1:0]         cnt;
    logic                      neg_q;
    logic                      neg_r;
    logic                      pqu_stall;
    logic                      issue_stall;
    logic                      pend;
    logic                      div_busy;
    logic [XLEN-1:0]           read_data;
  } state_type;

  state_type           st;
  state_type           next_st;
  logic [XLEN-1:0]     opa;
  logic [XLEN-1:0]     opb;
  logic [63:0]         hl;
  logic [63:0]         p1;
  logic [63:0]         prod;
  logic [XLEN:0]       a33;
  logic [HALFW:0]      blo;
  logic [XLEN:0]       shifted;
  logic [XLEN-1:0]     ua;
  logic [XLEN-1:0]     ub;
  logic [COUNTW-1:0]   lead_cnt;
  logic                take;
  logic                pqu_op;
  logic                sgn;
  logic                short_b;
  int                  skip;
  int                  lat;

  // Radix-4 booth product of a 33-bit and a 17-bit signed operand
  function automatic logic signed [49:0] booth_mul(input logic signed [32:0] a,
                                                   input logic signed [16:0] b);
    logic        [18:0] bx;
    logic signed [49:0] sum;
    logic signed [49:0] pp;
    bx = {b[16], b, 1'b0};
    sum = '0;
    for (int i = 0; i < 9; i++) begin
      case (bx[2*i +: 3])
        3'h1, 3'h2: pp = 50'(a);
        3'h3:       pp = 50'(a) <<< 1;
        3'h4:       pp = -(50'(a) <<< 1);
        3'h5, 3'h6: pp = -50'(a);
        default:    pp = '0;
      endcase
      sum = sum + (pp <<< (2 * i));
    end
    return sum;
  endfunction

  // True when the word is the sign or zero extension of its low n bits
  function automatic logic fits_width(input logic [XLEN-1:0] w, input int n, input logic s);
    logic [XLEN-1:0] ext;
    ext = (s && w[n-1]) ? 32'hFFFF_FFFF : 32'h0000_0000;
    return (w >> n) == (ext >> n);
  endfunction

  // Product into the result register pair: load, add or deduct
  function automatic logic [63:0] accumulate(input logic [1:0] mode, input logic [63:0] cur,
                                             input logic [63:0] p);
    case (mode)
      ACC_ADD: return cur + p;
      ACC_SUB: return cur - p;
      default: return p;
    endcase
  endfunction

  // Register read with forwarding from the pending writeback and the load port
  function automatic logic [XLEN-1:0] operand(input logic [IDXW-1:0] idx);
    if (st.res_valid && st.res_idx == idx) begin
      return st.res;
    end else if (load_valid_i && load_idx_i == idx) begin
      return load_data_i;
    end
    return st.regs[idx];
  endfunction

  lead_count #(
    .WIDTH (XLEN),
    .CW    (COUNTW)
  ) u_lead_count (
    .word_i  (opa),
    .ones_i  (op_i == LEADING_ONE_COUNT_OP),
    .count_o (lead_cnt)
  );

  // Next state of the whole unit
  always_comb begin
    next_st = st;
    next_st.res_valid = 1'b0;
    next_st.mulw_valid = 1'b0;
    prod = '0;
    shifted = '0;
    skip = 0;
    lat = DIV_LAT_32;
    // Register file writes: load, long register product, then pipeline result
    if (load_valid_i) next_st.regs[load_idx_i] = load_data_i;
    if (st.mulw_valid) next_st.regs[st.dest] = st.mulw;
    if (st.res_valid) next_st.regs[st.res_idx] = st.res;
    next_st.read_data = st.regs[read_idx_i];
    // Unit pipeline runs regardless of issue
    case (st.mst)
      PQU_PASS2: begin
        prod = st.acc + (64'(booth_mul(st.a33, st.bhi)) << HALFW);
        if (st.to_reg) begin
          next_st.mulw = prod[XLEN-1:0];
          next_st.mulw_valid = 1'b1;
        end else begin
          {next_st.up, next_st.bot} = accumulate(st.mode, {st.up, st.bot}, prod);
        end
        next_st.mst = PQU_IDLE;
      end
      PQU_DIV: begin
        if (st.iters != '0) begin
          shifted = {st.rem, st.quo[XLEN-1]};
          if (shifted >= {1'b0, st.dvs}) begin
            next_st.rem = XLEN'(shifted - {1'b0, st.dvs});
            next_st.quo = {st.quo[XLEN-2:0], 1'b1};
          end else begin
            next_st.rem = shifted[XLEN-1:0];
            next_st.quo = {st.quo[XLEN-2:0], 1'b0};
          end
          next_st.iters = st.iters - 1'b1;
        end
        if (st.cnt == '0) begin
          next_st.bot = st.neg_q ? -next_st.quo : next_st.quo;
          next_st.up = st.neg_r ? -next_st.rem : next_st.rem;
          next_st.mst = PQU_IDLE;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      default: begin
      end
    endcase
    // Pair as seen by a unit instruction, including a divide finishing now
    hl = {next_st.up, next_st.bot};
    opa = operand(src_a_idx_i);
    opb = operand(src_b_idx_i);
    pqu_op = op_i inside {[SIGNED_PRODUCT_OP:READ_LOWER_OP]};
    take = issue_valid_i && !st.issue_stall && !(pqu_op && st.pqu_stall);
    // Operand size detection from source B alone
    sgn = op_i inside {SIGNED_PRODUCT_OP, SIGNED_PRODUCT_ACCUMULATE_OP,
                       SIGNED_PRODUCT_DEDUCT_OP, REG_PRODUCT_OP};
    short_b = fits_width(opb, HALFW, sgn);
    a33 = {sgn & opa[XLEN-1], opa};
    blo = short_b ? {sgn & opb[HALFW-1], opb[HALFW-1:0]} : {1'b0, opb[HALFW-1:0]};
    p1 = 64'(booth_mul(a33, blo));
    ua = (op_i == SIGNED_QUOTIENT_OP && opa[XLEN-1]) ? -opa : opa;
    ub = (op_i == SIGNED_QUOTIENT_OP && opb[XLEN-1]) ? -opb : opb;
    // Early-in width of the dividend
    if (fits_width(opa, DIV_W8, op_i == SIGNED_QUOTIENT_OP)) begin
      skip = DIV_SKIP_8;
      lat = DIV_LAT_8;
    end else if (fits_width(opa, DIV_W16, op_i == SIGNED_QUOTIENT_OP)) begin
      skip = DIV_SKIP_16;
      lat = DIV_LAT_16;
    end else if (fits_width(opa, DIV_W24, op_i == SIGNED_QUOTIENT_OP)) begin
      skip = DIV_SKIP_24;
      lat = DIV_LAT_24;
    end
    // Issue of the presented instruction
    if (take) begin
      next_st.res_idx = dest_idx_i;
      next_st.res_valid = 1'b1;
      case (op_i)
        OP_ADD:                next_st.res = opa + opb;
        OP_SUB:                next_st.res = opa - opb;
        OP_AND:                next_st.res = opa & opb;
        OP_OR:                 next_st.res = opa | opb;
        OP_XOR:                next_st.res = opa ^ opb;
        OP_NOR:                next_st.res = ~(opa | opb);
        OP_SLL:                next_st.res = opa << opb[4:0];
        OP_SRL:                next_st.res = opa >> opb[4:0];
        OP_SRA:                next_st.res = XLEN'($signed(opa) >>> opb[4:0]);
        LEADING_ZERO_COUNT_OP,
        LEADING_ONE_COUNT_OP:  next_st.res = XLEN'(lead_cnt);
        READ_UPPER_OP:         next_st.res = hl[63:XLEN];
        READ_LOWER_OP:         next_st.res = hl[XLEN-1:0];
        SIGNED_PRODUCT_OP, UNSIGNED_PRODUCT_OP, SIGNED_PRODUCT_ACCUMULATE_OP,
        UNSIGNED_PRODUCT_ACCUMULATE_OP, SIGNED_PRODUCT_DEDUCT_OP,
        UNSIGNED_PRODUCT_DEDUCT_OP, REG_PRODUCT_OP: begin
          next_st.to_reg = op_i == REG_PRODUCT_OP;
          next_st.res_valid = short_b && op_i == REG_PRODUCT_OP;
          next_st.res = p1[XLEN-1:0];
          next_st.mode = (op_i inside {SIGNED_PRODUCT_ACCUMULATE_OP,
                                       UNSIGNED_PRODUCT_ACCUMULATE_OP}) ? ACC_ADD :
                         (op_i inside {SIGNED_PRODUCT_DEDUCT_OP,
                                       UNSIGNED_PRODUCT_DEDUCT_OP}) ? ACC_SUB : ACC_SET;
          if (short_b && op_i != REG_PRODUCT_OP) begin
            {next_st.up, next_st.bot} = accumulate(next_st.mode, hl, p1);
          end else if (!short_b) begin
            next_st.acc = p1;
            next_st.a33 = a33;
            next_st.bhi = {sgn & opb[XLEN-1], opb[XLEN-1:HALFW]};
            next_st.dest = dest_idx_i;
            next_st.mst = PQU_PASS2;
          end
        end
        SIGNED_QUOTIENT_OP, UNSIGNED_QUOTIENT_OP: begin
          next_st.res_valid = 1'b0;
          next_st.neg_q = (op_i == SIGNED_QUOTIENT_OP) && (opa[XLEN-1] ^ opb[XLEN-1]);
          next_st.neg_r = (op_i == SIGNED_QUOTIENT_OP) && opa[XLEN-1];
          next_st.quo = ua << skip;
          next_st.rem = '0;
          next_st.dvs = ub;
          next_st.iters = COUNTW'(XLEN - skip);
          next_st.cnt = COUNTW'(lat - 2);
          next_st.mst = PQU_DIV;
        end
        default: next_st.res_valid = 1'b0;
      endcase
    end
    // Interlocks for the following cycle
    next_st.pqu_stall = (next_st.mst == PQU_PASS2) ||
                        (next_st.mst == PQU_DIV && next_st.cnt != '0);
    next_st.issue_stall = next_st.mst == PQU_PASS2 && next_st.to_reg;
    next_st.pend = next_st.issue_stall || next_st.mulw_valid;
    next_st.div_busy = next_st.mst == PQU_DIV;
  end

  // State register
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign read_data_o = st.read_data;
  assign result_o = st.res;
  assign result_idx_o = st.res_idx;
  assign result_valid_o = st.res_valid;
  assign issue_stall_o = st.issue_stall;
  assign pqu_stall_o = st.pqu_stall;
  assign pending_valid_o = st.pend;
  assign pending_idx_o = st.dest;
  assign div_busy_o = st.div_busy;
  assign upper_result_o = st.up;
  assign bottom_result_o = st.bot;

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_long_hl;
    take && op_i == UNSIGNED_PRODUCT_OP && opb[XLEN-1:HALFW] != '0;
  endsequence
  sequence s_div8;
    take && op_i == UNSIGNED_QUOTIENT_OP && opa[XLEN-1:DIV_W8] == '0 && opb != '0;
  endsequence
  sequence s_div32;
    take && op_i == UNSIGNED_QUOTIENT_OP && opa[XLEN-1] && opb != '0;
  endsequence

  property p_alu_add;
    take && op_i == OP_ADD |=> result_valid_o && result_o == $past(opa + opb);
  endproperty
  a_alu_add: assert property (p_alu_add) else $error("add result not one cycle");
  property p_load_read;
    load_valid_i && !st.res_valid && !st.mulw_valid ##1 read_idx_i == $past(load_idx_i)
      |=> read_data_o == $past(load_data_i, 2);
  endproperty
  a_load_read: assert property (p_load_read) else $error("register lost load");
  property p_lzc_zero;
    take && op_i == LEADING_ZERO_COUNT_OP && opa == '0 |=> result_o == XLEN'(XLEN);
  endproperty
  a_lzc_zero: assert property (p_lzc_zero) else $error("zero count of zero wrong");
  property p_bypass;
    take && op_i == OP_OR && result_valid_o && src_a_idx_i == result_idx_o &&
      src_b_idx_i == result_idx_o |=> result_o == $past(result_o);
  endproperty
  a_bypass: assert property (p_bypass) else $error("forwarded value wrong");
  property p_div_advances;
    st.mst == PQU_DIV && st.cnt != '0 |=> st.mst == PQU_DIV && st.cnt == $past(st.cnt) - 1'b1;
  endproperty
  a_div_advances: assert property (p_div_advances) else $error("divide stalled");
  property p_short_mul;
    take && op_i == UNSIGNED_PRODUCT_OP && opb[XLEN-1:HALFW] == '0 |=> !pqu_stall_o &&
      {upper_result_o, bottom_result_o} == $past(64'(opa) * 64'(opb));
  endproperty
  a_short_mul: assert property (p_short_mul) else $error("short product wrong");
  property p_long_mul;
    s_long_hl |=> pqu_stall_o ##1
      (!pqu_stall_o && {upper_result_o, bottom_result_o} == $past(64'(opa) * 64'(opb), 2));
  endproperty
  a_long_mul: assert property (p_long_mul) else $error("full product timing wrong");
  property p_pass2_stall;
    st.mst == PQU_PASS2 |-> pqu_stall_o;
  endproperty
  a_pass2_stall: assert property (p_pass2_stall) else $error("second pass not stalled");
  property p_div_stall;
    st.mst == PQU_DIV && st.cnt != '0 |-> pqu_stall_o && div_busy_o;
  endproperty
  a_div_stall: assert property (p_div_stall) else $error("divide not interlocked");
  // Finished pair seen by an op issued in the last divide cycle
  property p_div8;
    s_div8 |-> ##10 pqu_stall_o ##1
      (!pqu_stall_o && hl[XLEN-1:0] == $past(opa, 11) / $past(opb, 11));
  endproperty
  a_div8: assert property (p_div8) else $error("8-bit divide timing wrong");
  property p_div32_rem;
    s_div32 ##32 !(take && pqu_op) |=> upper_result_o == $past(opa, 33) % $past(opb, 33);
  endproperty
  a_div32_rem: assert property (p_div32_rem) else $error("remainder wrong");
  property p_gpr_long;
    take && op_i == REG_PRODUCT_OP && !short_b |=> issue_stall_o ##1
      (!issue_stall_o && pending_valid_o) ##1 (!pending_valid_o || issue_stall_o);
  endproperty
  a_gpr_long: assert property (p_gpr_long) else $error("register product timing");
endmodule
`default_nettype wire

// file: design/exec_unit_pkg.sv
/*
  Shared constants and types of the integer execution unit:
  operation codes, product/quotient unit states, widths and timing counts.
  Assumes nothing of its surroundings.
*/
package exec_unit_pkg;
  localparam int XLEN = 32;
  localparam int NUM_GENERAL_REGS = 32;
  localparam int IDXW = 5;
  localparam int HALFW = 16;
  localparam int COUNTW = 6;
  // Dividend widths and iterations skipped by the early-in check
  localparam int DIV_W8 = 8;
  localparam int DIV_W16 = 16;
  localparam int DIV_W24 = 24;
  localparam int DIV_SKIP_8 = 23;
  localparam int DIV_SKIP_16 = 15;
  localparam int DIV_SKIP_24 = 7;
  // Divide latencies in core clocks; repeat is one less
  localparam int DIV_LAT_8 = 12;
  localparam int DIV_LAT_16 = 19;
  localparam int DIV_LAT_24 = 26;
  localparam int DIV_LAT_32 = 33;
  // Accumulate modes of a product
  localparam logic [1:0] ACC_SET = 2'h0;
  localparam logic [1:0] ACC_ADD = 2'h1;
  localparam logic [1:0] ACC_SUB = 2'h2;

  typedef enum logic [4:0] {
    OP_NOP                         = 5'h00,
    OP_ADD                         = 5'h01,
    OP_SUB                         = 5'h02,
    OP_AND                         = 5'h03,
    OP_OR                          = 5'h04,
    OP_XOR                         = 5'h05,
    OP_NOR                         = 5'h06,
    OP_SLL                         = 5'h07,
    OP_SRL                         = 5'h08,
    OP_SRA                         = 5'h09,
    LEADING_ZERO_COUNT_OP          = 5'h0A,
    LEADING_ONE_COUNT_OP           = 5'h0B,
    SIGNED_PRODUCT_OP              = 5'h0C,
    UNSIGNED_PRODUCT_OP            = 5'h0D,
    SIGNED_PRODUCT_ACCUMULATE_OP   = 5'h0E,
    UNSIGNED_PRODUCT_ACCUMULATE_OP = 5'h0F,
    SIGNED_PRODUCT_DEDUCT_OP       = 5'h10,
    UNSIGNED_PRODUCT_DEDUCT_OP     = 5'h11,
    REG_PRODUCT_OP                 = 5'h12,
    SIGNED_QUOTIENT_OP             = 5'h13,
    UNSIGNED_QUOTIENT_OP           = 5'h14,
    READ_UPPER_OP                  = 5'h15,
    READ_LOWER_OP                  = 5'h16
  } op_type;

  typedef enum logic [1:0] {
    PQU_IDLE  = 2'h0,
    PQU_PASS2 = 2'h1,
    PQU_DIV   = 2'h2
  } pqu_state_type;
endpackage

// file: design/lead_count.sv
/*
  Leading zero / leading one counter of one word.
  Assumes a combinational caller; output settles within the cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module lead_count #(
  parameter int WIDTH = 32,
  parameter int CW    = 6
) (
  input  wire logic [WIDTH-1:0] word_i,
  input  wire logic             ones_i,
  output logic      [CW-1:0]    count_o
);
  // Highest bit that differs from the counted value ends the run
  always_comb begin
    count_o = CW'(WIDTH);
    for (int i = 0; i < WIDTH; i++) begin
      if (word_i[i] != ones_i) begin
        count_o = CW'(WIDTH - 1 - i);
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/pipe_model.sv
/* Integer pipeline model: presents instructions and load writebacks.
   Assumes every call starts just after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module pipe_model import exec_unit_pkg::*; (
  input  wire logic            core_clk_i,
  input  wire logic            issue_stall_i,
  input  wire logic            pqu_stall_i,
  output var  op_type          op_o,
  output logic                 issue_valid_o,
  output logic      [IDXW-1:0] src_a_idx_o,
  output logic      [IDXW-1:0] src_b_idx_o,
  output logic      [IDXW-1:0] dest_idx_o,
  output logic                 load_valid_o,
  output logic      [IDXW-1:0] load_idx_o,
  output logic      [XLEN-1:0] load_data_o
);
  int cyc;
  // Quiet outputs at time zero
  initial begin
    {issue_valid_o, load_valid_o, src_a_idx_o, src_b_idx_o, dest_idx_o, load_idx_o} = '0;
    op_o = OP_NOP;
    load_data_o = '0;
    cyc = 0;
  end
  // Edge count used to time takes
  always @(posedge core_clk_i) cyc <= cyc + 1;
  // Present one instruction, keep it until an edge takes it
  task automatic issue(input op_type op, input logic [IDXW-1:0] a, b, d, output int tc);
    logic taken;
    issue_valid_o = 1'b1;
    op_o = op;
    {src_a_idx_o, src_b_idx_o, dest_idx_o} = {a, b, d};
    taken = 1'b0;
    while (!taken) begin
      @(negedge core_clk_i);
      taken = !issue_stall_i && !(op >= SIGNED_PRODUCT_OP && pqu_stall_i);
      tc = cyc;
      @(posedge core_clk_i);
    end
    #1;
  endtask
  // Withdraw the instruction, scramble its fields
  task automatic idle;
    issue_valid_o = 1'b0;
    op_o = OP_NOP;
    {src_a_idx_o, src_b_idx_o, dest_idx_o} = ~{src_a_idx_o, src_b_idx_o, dest_idx_o};
  endtask
  // One load writeback, then a quiet cycle
  task automatic load(input logic [IDXW-1:0] idx, input logic [XLEN-1:0] data);
    {load_valid_o, load_idx_o, load_data_o} = {1'b1, idx, data};
    @(posedge core_clk_i);
    #1 {load_valid_o, load_data_o} = {1'b0, ~data};
    @(posedge core_clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// file: bench/integer_exec_signed_product_op_div_unit_tb.sv
/* Self-checking bench of the execution unit.
   Assumes the pipeline model drives all issue and load inputs. */
`timescale 1ns/100ps
`default_nettype none
module integer_exec_signed_product_op_div_unit_tb import exec_unit_pkg::*;;
  logic            core_clk_i, resetn_i, iv, lv, is, ms, pv, res_v, busy;
  op_type          op;
  logic [IDXW-1:0] ai, bi, di, li, read_idx_i, res_idx, pidx;
  logic [XLEN-1:0] ld, rdat, res, up, bot, rv [0:12];
  logic [63:0]     acc;
  int              num_errors, samples_checked, tc, tp;
  exec_unit dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .issue_valid_i(iv),
    .op_i(op), .src_a_idx_i(ai), .src_b_idx_i(bi), .dest_idx_i(di), .load_valid_i(lv),
    .load_idx_i(li), .load_data_i(ld), .read_idx_i(read_idx_i), .read_data_o(rdat),
    .result_o(res), .result_idx_o(res_idx), .result_valid_o(res_v), .issue_stall_o(is),
    .pqu_stall_o(ms), .pending_valid_o(pv), .pending_idx_o(pidx), .div_busy_o(busy),
    .upper_result_o(up), .bottom_result_o(bot));
  pipe_model pipe_u (.core_clk_i(core_clk_i), .issue_stall_i(is), .pqu_stall_i(ms),
    .op_o(op), .issue_valid_o(iv), .src_a_idx_o(ai), .src_b_idx_o(bi), .dest_idx_o(di),
    .load_valid_o(lv), .load_idx_o(li), .load_data_o(ld));
  // Compare and count
  task automatic check(input logic [XLEN-1:0] seen, input logic [XLEN-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Writeback expected in the cycle after the take
  task automatic exp_res(input logic [XLEN-1:0] exp, input logic [IDXW-1:0] idx);
    fork
      begin
        @(negedge core_clk_i);
        check(32'(res_v), 32'h1);
        check(res, exp);
        check(32'(res_idx), 32'(idx));
      end
    join_none
  endtask
  task automatic read_chk(input logic [IDXW-1:0] idx, input logic [XLEN-1:0] exp);
    read_idx_i = idx;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    check(rdat, exp);
    @(posedge core_clk_i);
    #1;
  endtask
  function automatic logic [XLEN-1:0] alu(op_type o, logic [XLEN-1:0] a, b);
    case (o)
      OP_ADD: return a + b;
      OP_SUB: return a - b;
      OP_AND: return a & b;
      OP_OR: return a | b;
      OP_XOR: return a ^ b;
      OP_NOR: return ~(a | b);
      OP_SLL: return a << b[4:0];
      OP_SRL: return a >> b[4:0];
      default: return $signed(a) >>> b[4:0];
    endcase
  endfunction
  // New result pair after a product op
  function automatic logic [63:0] apply(logic [63:0] c, op_type o, logic [XLEN-1:0] a, b);
    logic s;
    logic [63:0] p;
    s = o inside {SIGNED_PRODUCT_OP, SIGNED_PRODUCT_ACCUMULATE_OP, SIGNED_PRODUCT_DEDUCT_OP};
    p = {{32{s & a[31]}}, a} * {{32{s & b[31]}}, b};
    if (o inside {SIGNED_PRODUCT_ACCUMULATE_OP, UNSIGNED_PRODUCT_ACCUMULATE_OP}) return c + p;
    if (o inside {SIGNED_PRODUCT_DEDUCT_OP, UNSIGNED_PRODUCT_DEDUCT_OP}) return c - p;
    return p;
  endfunction
  task automatic t_regs;
    for (int i = 1; i <= 12; i++) pipe_u.load(5'(i), rv[i]);
    read_chk(5'h1F, 32'h0);
    for (int i = 1; i <= 12; i++) read_chk(5'(i), rv[i]);
    $display("registers done");
  endtask
  task automatic t_alu;
    for (int o = 1; o <= 9; o++) begin
      pipe_u.issue(op_type'(o), 5'h1, 5'h2, 5'h14, tc);
      exp_res(alu(op_type'(o), rv[1], rv[2]), 5'h14);
    end
    pipe_u.issue(OP_ADD, 5'h1, 5'h2, 5'h15, tc);
    exp_res(rv[1] + rv[2], 5'h15);
    pipe_u.issue(OP_SUB, 5'h15, 5'h1, 5'h16, tc);
    exp_res(rv[2], 5'h16);
    pipe_u.issue(LEADING_ZERO_COUNT_OP, 5'h3, 5'h0, 5'h17, tc);
    exp_res(32'h13, 5'h17);
    pipe_u.issue(LEADING_ONE_COUNT_OP, 5'h4, 5'h0, 5'h17, tc);
    exp_res(32'h1D, 5'h17);
    pipe_u.issue(LEADING_ZERO_COUNT_OP, 5'h9, 5'h0, 5'h17, tc);
    exp_res(32'h0, 5'h17);
    pipe_u.idle();
    @(posedge core_clk_i);
    #1 $display("alu done");
  endtask
  task automatic t_mul;
    op_type po [6] = '{UNSIGNED_PRODUCT_OP, UNSIGNED_PRODUCT_ACCUMULATE_OP,
      SIGNED_PRODUCT_DEDUCT_OP, SIGNED_PRODUCT_OP, SIGNED_PRODUCT_ACCUMULATE_OP,
      UNSIGNED_PRODUCT_DEDUCT_OP};
    int pa [6] = '{1, 1, 4, 4, 4, 1};
    int pb [6] = '{3, 2, 3, 2, 3, 3};
    // One op at a time: latency and stall
    for (int i = 0; i < 6; i++) begin
      pipe_u.issue(po[i], 5'(pa[i]), 5'(pb[i]), 5'h0, tc);
      pipe_u.idle();
      @(negedge core_clk_i);
      if (pb[i] == 2) begin
        check(32'(ms), 32'h1);
        check(bot, acc[31:0]);
        @(negedge core_clk_i);
      end
      acc = apply(acc, po[i], rv[pa[i]], rv[pb[i]]);
      check(up, acc[63:32]);
      check(bot, acc[31:0]);
      @(posedge core_clk_i);
      #1;
    end
    // Back to back: issue spacing
    pipe_u.issue(po[0], 5'h1, 5'h3, 5'h0, tp);
    acc = apply(acc, po[0], rv[1], rv[3]);
    for (int i = 1; i < 6; i++) begin
      pipe_u.issue(po[i], 5'(pa[i]), 5'(pb[i]), 5'h0, tc);
      check(32'(tc - tp), (pb[i - 1] == 2) ? 32'h2 : 32'h1);
      acc = apply(acc, po[i], rv[pa[i]], rv[pb[i]]);
      tp = tc;
    end
    pipe_u.idle();
    @(negedge core_clk_i);
    check(bot, acc[31:0]);
    check(up, acc[63:32]);
    @(posedge core_clk_i);
    #1 $display("products done");
  endtask
  task automatic t_gpr;
    pipe_u.issue(REG_PRODUCT_OP, 5'h1, 5'h3, 5'h18, tp);
    exp_res(rv[1] * rv[3], 5'h18);
    pipe_u.issue(REG_PRODUCT_OP, 5'h1, 5'h2, 5'h19, tp);
    fork
      begin
        @(negedge core_clk_i);
        check({30'h0, pv, is}, 32'h3);
        check(32'(pidx), 32'h19);
      end
    join_none
    pipe_u.issue(REG_PRODUCT_OP, 5'h1, 5'h3, 5'h1A, tc);
    check(32'(tc - tp), 32'h2);
    exp_res(rv[1] * rv[3], 5'h1A);
    pipe_u.idle();
    read_chk(5'h19, rv[1] * rv[2]);
    $display("register products done");
  endtask
  task automatic t_div;
    op_type dop [4] = '{UNSIGNED_QUOTIENT_OP, SIGNED_QUOTIENT_OP, UNSIGNED_QUOTIENT_OP,
      UNSIGNED_QUOTIENT_OP};
    int da [4] = '{5, 7, 8, 9};
    int dv [4] = '{6, 6, 11, 10};
    int lat [4] = '{12, 19, 26, 33};
    logic [XLEN-1:0] q [4] = '{32'h1C, 32'hFFFFFF72, 32'h12345, 32'h2AAAAAAA};
    logic [XLEN-1:0] r [4] = '{32'h4, 32'hFFFFFFFA, 32'h6, 32'h2};
    for (int i = 0; i < 4; i++) begin
      pipe_u.issue(dop[i], 5'(da[i]), 5'(dv[i]), 5'h0, tc);
      pipe_u.idle();
      @(negedge core_clk_i);
      check({30'h0, busy, ms}, 32'h3);
      repeat (lat[i] - 2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      check({30'h0, busy, ms}, 32'h2);
      @(negedge core_clk_i);
      check(32'(busy), 32'h0);
      check(bot, q[i]);
      check(up, r[i]);
      @(posedge core_clk_i);
      #1;
    end
    // Pipeline keeps flowing, unit ops wait for the divide
    pipe_u.issue(UNSIGNED_QUOTIENT_OP, 5'h5, 5'h6, 5'h0, tp);
    pipe_u.issue(OP_ADD, 5'h1, 5'h2, 5'h1B, tc);
    exp_res(rv[1] + rv[2], 5'h1B);
    check(32'(tc - tp), 32'h1);
    pipe_u.issue(UNSIGNED_PRODUCT_OP, 5'h1, 5'h3, 5'h0, tc);
    check(32'(tc - tp), 32'hB);
    pipe_u.idle();
    @(negedge core_clk_i);
    check(bot, rv[1] * rv[3]);
    @(posedge core_clk_i);
    #1 $display("divides done");
  endtask
  // Core clock, 100 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge core_clk_i);
    num_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {resetn_i, read_idx_i, num_errors, samples_checked, acc} = '0;
    rv = '{32'h0, 32'h12345678, 32'h89ABCDEF, 32'h1234, 32'hFFFFFFFB, 32'hC8, 32'h7,
      32'hFFFFFC18, 32'h123456, 32'h80000000, 32'h3, 32'h10, 32'h4};
    repeat (6) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    t_regs();
    t_alu();
    t_mul();
    t_gpr();
    t_div();
    end_sim();
  end
endmodule
`default_nettype wire
